// ### inc/tgds_pkg.sv
// Purpose: constants of the tape gap delay sequencer
// Assumes: 25 MHz system clock, nine-track transports only
// Notes: delay figures in ms, counted in 10 us speed-clock ticks
package tgds_pkg;

	// clock and speed clock
	localparam int unsigned CLOCK_NS = 40;
	localparam int unsigned TICK_US  = 10;
	localparam logic [15:0] TICK_CYC = 16'(TICK_US * 1000 / CLOCK_NS);

	// ms figure to whole speed-clock ticks
	function automatic int ms_to_ticks(input real ms);
		return int'(ms * 1000.0 / real'(TICK_US));
	endfunction

	// speed select codes
	localparam logic [1:0] SPD_75    = 2'h0;
	localparam logic [1:0] SPD_45    = 2'h1;
	localparam logic [1:0] SPD_37    = 2'h2;
	localparam logic [1:0] SPD_SCALE = 2'h3;

	// 75 ips figures
	localparam real PRE_RD_75_MS     = 3.66;
	localparam real PRE_WR_75_MS     = 5.66;
	localparam real PRE_RD_BOT_75_MS = 12.0;
	localparam real PRE_WR_BOT_75_MS = 53.6;
	localparam real HALT_75_MS       = 5.66;
	localparam real POST_FWD_75_MS   = 1.67;
	localparam real POST_EDSS_75_MS  = 0.33;
	localparam real POST_WRSS_75_MS  = 2.66;
	localparam real POST_EDDS_75_MS  = 2.33;
	// 45 ips figures
	localparam real PRE_RD_45_MS     = 6.08;
	localparam real PRE_WR_45_MS     = 9.4;
	localparam real PRE_RD_BOT_45_MS = 19.9;
	localparam real PRE_WR_BOT_45_MS = 89.0;
	localparam real HALT_45_MS       = 9.4;
	localparam real POST_FWD_45_MS   = 2.78;
	localparam real POST_EDSS_45_MS  = 0.54;
	localparam real POST_WRSS_45_MS  = 4.4;
	localparam real POST_EDDS_45_MS  = 3.86;
	// 37.5 ips figures
	localparam real PRE_RD_37_MS     = 7.3;
	localparam real PRE_WR_37_MS     = 11.3;
	localparam real PRE_RD_BOT_37_MS = 24.0;
	localparam real PRE_WR_BOT_37_MS = 107.3;
	localparam real HALT_37_MS       = 11.3;
	localparam real POST_FWD_37_MS   = 3.34;
	localparam real POST_EDSS_37_MS  = 0.66;
	localparam real POST_WRSS_37_MS  = 5.3;
	localparam real POST_EDDS_37_MS  = 4.64;

	// tick counts
	localparam logic [15:0] T_PRE_RD_75     = 16'(ms_to_ticks(PRE_RD_75_MS));
	localparam logic [15:0] T_PRE_WR_75     = 16'(ms_to_ticks(PRE_WR_75_MS));
	localparam logic [15:0] T_PRE_RD_BOT_75 = 16'(ms_to_ticks(PRE_RD_BOT_75_MS));
	localparam logic [15:0] T_PRE_WR_BOT_75 = 16'(ms_to_ticks(PRE_WR_BOT_75_MS));
	localparam logic [15:0] T_HALT_75       = 16'(ms_to_ticks(HALT_75_MS));
	localparam logic [15:0] T_POST_FWD_75   = 16'(ms_to_ticks(POST_FWD_75_MS));
	localparam logic [15:0] T_POST_EDSS_75  = 16'(ms_to_ticks(POST_EDSS_75_MS));
	localparam logic [15:0] T_POST_WRSS_75  = 16'(ms_to_ticks(POST_WRSS_75_MS));
	localparam logic [15:0] T_POST_EDDS_75  = 16'(ms_to_ticks(POST_EDDS_75_MS));
	localparam logic [15:0] T_PRE_RD_45     = 16'(ms_to_ticks(PRE_RD_45_MS));
	localparam logic [15:0] T_PRE_WR_45     = 16'(ms_to_ticks(PRE_WR_45_MS));
	localparam logic [15:0] T_PRE_RD_BOT_45 = 16'(ms_to_ticks(PRE_RD_BOT_45_MS));
	localparam logic [15:0] T_PRE_WR_BOT_45 = 16'(ms_to_ticks(PRE_WR_BOT_45_MS));
	localparam logic [15:0] T_HALT_45       = 16'(ms_to_ticks(HALT_45_MS));
	localparam logic [15:0] T_POST_FWD_45   = 16'(ms_to_ticks(POST_FWD_45_MS));
	localparam logic [15:0] T_POST_EDSS_45  = 16'(ms_to_ticks(POST_EDSS_45_MS));
	localparam logic [15:0] T_POST_WRSS_45  = 16'(ms_to_ticks(POST_WRSS_45_MS));
	localparam logic [15:0] T_POST_EDDS_45  = 16'(ms_to_ticks(POST_EDDS_45_MS));
	localparam logic [15:0] T_PRE_RD_37     = 16'(ms_to_ticks(PRE_RD_37_MS));
	localparam logic [15:0] T_PRE_WR_37     = 16'(ms_to_ticks(PRE_WR_37_MS));
	localparam logic [15:0] T_PRE_RD_BOT_37 = 16'(ms_to_ticks(PRE_RD_BOT_37_MS));
	localparam logic [15:0] T_PRE_WR_BOT_37 = 16'(ms_to_ticks(PRE_WR_BOT_37_MS));
	localparam logic [15:0] T_HALT_37       = 16'(ms_to_ticks(HALT_37_MS));
	localparam logic [15:0] T_POST_FWD_37   = 16'(ms_to_ticks(POST_FWD_37_MS));
	localparam logic [15:0] T_POST_EDSS_37  = 16'(ms_to_ticks(POST_EDSS_37_MS));
	localparam logic [15:0] T_POST_WRSS_37  = 16'(ms_to_ticks(POST_WRSS_37_MS));
	localparam logic [15:0] T_POST_EDDS_37  = 16'(ms_to_ticks(POST_EDDS_37_MS));

	// register map
	localparam logic [3:0] REG_CFG    = 4'h0;
	localparam logic [3:0] REG_SCALE  = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	// config fields
	localparam int unsigned CFG_SPD_LSB = 0;
	localparam int unsigned CFG_DUAL    = 2;
	localparam int unsigned CFG_EDIT    = 3;
	localparam logic [3:0]  CFG_RST     = 4'h4;
	localparam logic [15:0] SCALE_RST   = TICK_CYC;
	// status fields
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_DBUSY     = 3;
	localparam int unsigned ST_COMMAND_BUSY     = 4;
	localparam int unsigned ST_MOTION    = 5;
	localparam int unsigned ST_CNT_LSB   = 16;

	// sequencer states, gray from idle through halt; halt back to idle flips two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PRE  = 3'h1,
		ST_XFER = 3'h3,
		ST_POST = 3'h2,
		ST_HALT = 3'h6,
		ST_WLP  = 3'h4
	} tgds_state_e;

endpackage

// ### rtl/tgds_speed_clock.sv
// Purpose: speed clock tick generator for the delay counter
// Assumes: i_period at least 1
// Notes: one-cycle tick every i_period clocks
`timescale 1ns/1ns
`default_nettype none
module tgds_speed_clock (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// period in clock cycles
	input  wire logic [15:0] i_period,
	// tick out
	output logic             o_tick
);
	logic [15:0] count;

	// divider restarts on reset and at terminal count
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count  <= 16'h0000;
			o_tick <= 1'b0;
		end else if (count + 16'h0001 >= i_period) begin
			count  <= 16'h0000;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 16'h0001;
			o_tick <= 1'b0;
		end
	end
endmodule // tgds_speed_clock
`default_nettype wire

// ### rtl/tgds_sequencer.sv
// Purpose: predelay, postdelay and halt delay sequencing of a tape formatter
// Assumes: host pins asynchronous; end_record_state from same clock domain
// Notes: nine-track tables at 75, 45 and 37.5 ips; other speeds scaled
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tgds_sequencer (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// host command pins
	input  wire logic        i_command_strobe_n,
	input  wire logic        i_cmd_write,
	input  wire logic        i_cmd_reverse,
	input  wire logic        i_cmd_bot,
	// transport and formatter
	input  wire logic        i_load_point_marker,
	input  wire logic        i_end_record_state,
	output logic             o_motion,
	// busy lines to host
	output logic             o_data_busy,
	output logic             o_command_busy
);

	typedef struct packed {
		tgds_pkg::tgds_state_e state;
		logic [15:0] cnt;
		logic [1:0]  stb_sync;
		logic        stb_prev;
		logic [1:0]  lp_sync;
		logic        lp_prev;
		logic [1:0]  wr_sync;
		logic [1:0]  rev_sync;
		logic [1:0]  bot_sync;
		logic        end_prev;
		logic        op_write;
		logic        op_rev;
		logic        op_bot;
		logic [3:0]  cfg;
		logic [15:0] scale;
		logic [31:0] rdata;
		logic        data_busy;
		logic        cmd_busy;
		logic        motion;
	} tgds_regs_s;

	localparam tgds_regs_s REGS_RST = '{
		state:     tgds_pkg::ST_IDLE,
		cnt:       16'h0000,
		stb_sync:  2'h3,
		stb_prev:  1'b1,
		lp_sync:   2'h0,
		lp_prev:   1'b0,
		wr_sync:   2'h0,
		rev_sync:  2'h0,
		bot_sync:  2'h0,
		end_prev:  1'b0,
		op_write:  1'b0,
		op_rev:    1'b0,
		op_bot:    1'b0,
		cfg:       tgds_pkg::CFG_RST,
		scale:     tgds_pkg::SCALE_RST,
		rdata:     32'h0000_0000,
		data_busy: 1'b0,
		cmd_busy:  1'b0,
		motion:    1'b0
	};

	tgds_regs_s r;
	tgds_regs_s next_r;
	logic       tick;
	logic [15:0] tick_period;
	logic [1:0] spd;
	logic       dual;
	logic       edit;

	// config fields
	assign spd  = r.cfg[tgds_pkg::CFG_SPD_LSB +: 2];
	assign dual = r.cfg[tgds_pkg::CFG_DUAL];
	assign edit = r.cfg[tgds_pkg::CFG_EDIT];

	// speed clock period by speed setting
	assign tick_period = (spd == tgds_pkg::SPD_SCALE) ? r.scale : tgds_pkg::TICK_CYC;

	tgds_speed_clock u_speed_clock (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_period (tick_period),
		.o_tick   (tick)
	);

	// predelay by speed, write and tape start
	function automatic logic [15:0] pre_ticks(input logic [1:0] s, input logic w,
		input logic b);
		logic [15:0] v;
		v = 16'h0000;
		case (s)
			tgds_pkg::SPD_45: begin
				v = b ? (w ? tgds_pkg::T_PRE_WR_BOT_45 : tgds_pkg::T_PRE_RD_BOT_45)
				      : (w ? tgds_pkg::T_PRE_WR_45 : tgds_pkg::T_PRE_RD_45);
			end
			tgds_pkg::SPD_37: begin
				v = b ? (w ? tgds_pkg::T_PRE_WR_BOT_37 : tgds_pkg::T_PRE_RD_BOT_37)
				      : (w ? tgds_pkg::T_PRE_WR_37 : tgds_pkg::T_PRE_RD_37);
			end
			default: begin
				v = b ? (w ? tgds_pkg::T_PRE_WR_BOT_75 : tgds_pkg::T_PRE_RD_BOT_75)
				      : (w ? tgds_pkg::T_PRE_WR_75 : tgds_pkg::T_PRE_RD_75);
			end
		endcase
		return v;
	endfunction

	// halt delay by speed
	function automatic logic [15:0] halt_ticks(input logic [1:0] s);
		logic [15:0] v;
		v = 16'h0000;
		case (s)
			tgds_pkg::SPD_45: v = tgds_pkg::T_HALT_45;
			tgds_pkg::SPD_37: v = tgds_pkg::T_HALT_37;
			default:          v = tgds_pkg::T_HALT_75;
		endcase
		return v;
	endfunction

	// postdelay by head stack, direction, write and edit
	function automatic logic [15:0] post_ticks(input logic [1:0] s, input logic w,
		input logic rv, input logic ds, input logic ed);
		logic [15:0] fwd;
		logic [15:0] edss;
		logic [15:0] wrss;
		logic [15:0] edds;
		logic [15:0] v;
		fwd  = tgds_pkg::T_POST_FWD_75;
		edss = tgds_pkg::T_POST_EDSS_75;
		wrss = tgds_pkg::T_POST_WRSS_75;
		edds = tgds_pkg::T_POST_EDDS_75;
		case (s)
			tgds_pkg::SPD_45: begin
				fwd  = tgds_pkg::T_POST_FWD_45;
				edss = tgds_pkg::T_POST_EDSS_45;
				wrss = tgds_pkg::T_POST_WRSS_45;
				edds = tgds_pkg::T_POST_EDDS_45;
			end
			tgds_pkg::SPD_37: begin
				fwd  = tgds_pkg::T_POST_FWD_37;
				edss = tgds_pkg::T_POST_EDSS_37;
				wrss = tgds_pkg::T_POST_WRSS_37;
				edds = tgds_pkg::T_POST_EDDS_37;
			end
			default: begin
				fwd = fwd;
			end
		endcase
		// dual stack write post equals single stack edit figure
		if (w) begin
			v = ds ? edss : wrss;
		end else if (!rv) begin
			v = ds ? 16'h0000 : fwd;
		end else if (ed) begin
			v = ds ? edds : edss;
		end else begin
			v = ds ? fwd : 16'h0000;
		end
		return v;
	endfunction

	// next-state logic
	always_comb begin
		next_r = r;
		// pin synchronisers; first stage read only by the second
		next_r.stb_sync = {r.stb_sync[0], i_command_strobe_n};
		next_r.stb_prev = r.stb_sync[1];
		next_r.lp_sync  = {r.lp_sync[0], i_load_point_marker};
		next_r.lp_prev  = r.lp_sync[1];
		next_r.wr_sync  = {r.wr_sync[0], i_cmd_write};
		next_r.rev_sync = {r.rev_sync[0], i_cmd_reverse};
		next_r.bot_sync = {r.bot_sync[0], i_cmd_bot};
		next_r.end_prev = i_end_record_state;

		// register writes
		if (i_wr && i_addr == tgds_pkg::REG_CFG) begin
			next_r.cfg = i_wdata[3:0];
		end
		if (i_wr && i_addr == tgds_pkg::REG_SCALE) begin
			next_r.scale = (i_wdata[15:0] == 16'h0000) ? 16'h0001 : i_wdata[15:0];
		end

		// register reads, data only in the following cycle
		next_r.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				tgds_pkg::REG_CFG:   next_r.rdata = {28'h0000000, r.cfg};
				tgds_pkg::REG_SCALE: next_r.rdata = {16'h0000, r.scale};
				tgds_pkg::REG_STATUS: begin
					next_r.rdata[tgds_pkg::ST_STATE_LSB +: 3] = r.state;
					next_r.rdata[tgds_pkg::ST_DBUSY]          = r.data_busy;
					next_r.rdata[tgds_pkg::ST_COMMAND_BUSY]          = r.cmd_busy;
					next_r.rdata[tgds_pkg::ST_MOTION]         = r.motion;
					next_r.rdata[tgds_pkg::ST_CNT_LSB +: 16]  = r.cnt;
				end
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end

		// single delay counter, stepped by the speed clock
		if (tick && r.cnt != 16'h0000) begin
			next_r.cnt = r.cnt - 16'h0001;
		end

		// sequencer
		case (r.state)
			tgds_pkg::ST_IDLE: begin
				// strobe falling edge starts an operation
				if (r.stb_prev && !r.stb_sync[1]) begin
					next_r.op_write = r.wr_sync[1];
					next_r.op_rev   = r.rev_sync[1];
					next_r.op_bot   = r.bot_sync[1];
					next_r.cmd_busy = 1'b1;
					next_r.motion   = 1'b1;
					if (r.bot_sync[1]) begin
						next_r.state = tgds_pkg::ST_WLP;
					end else begin
						next_r.cnt   = pre_ticks(spd, r.wr_sync[1], 1'b0);
						next_r.state = tgds_pkg::ST_PRE;
					end
				end
			end
			tgds_pkg::ST_WLP: begin
				// at tape start, predelay runs from load point rise
				if (r.lp_sync[1] && !r.lp_prev) begin
					next_r.cnt   = pre_ticks(spd, r.op_write, 1'b1);
					next_r.state = tgds_pkg::ST_PRE;
				end
			end
			tgds_pkg::ST_PRE: begin
				// predelay end opens the record window
				if (r.cnt == 16'h0000) begin
					next_r.data_busy = 1'b1;
					next_r.state     = tgds_pkg::ST_XFER;
				end
			end
			tgds_pkg::ST_XFER: begin
				// end of record rise starts the postdelay
				if (i_end_record_state && !r.end_prev) begin
					next_r.cnt   = post_ticks(spd, r.op_write, r.op_rev, dual, edit);
					next_r.state = tgds_pkg::ST_POST;
				end
			end
			tgds_pkg::ST_POST: begin
				// postdelay end drops data busy and motion
				if (r.cnt == 16'h0000) begin
					next_r.data_busy = 1'b0;
					next_r.motion    = 1'b0;
					next_r.cnt       = halt_ticks(spd);
					next_r.state     = tgds_pkg::ST_HALT;
				end
			end
			tgds_pkg::ST_HALT: begin
				// halt delay end releases command busy
				if (r.cnt == 16'h0000) begin
					next_r.cmd_busy = 1'b0;
					next_r.state    = tgds_pkg::ST_IDLE;
				end
			end
			default: begin
				next_r.state     = tgds_pkg::ST_IDLE;
				next_r.data_busy = 1'b0;
				next_r.cmd_busy  = 1'b0;
				next_r.motion    = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			r <= REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	// outputs from flops
	assign o_rdata        = r.rdata;
	assign o_motion       = r.motion;
	assign o_data_busy    = r.data_busy;
	assign o_command_busy = r.cmd_busy;

endmodule // tgds_sequencer
`default_nettype wire

// ### sim/tgds_sequencer_monitor.sv
// Purpose: port-level checks on the gap delay sequencer
// Assumes: single clock, synchronous active-high reset
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module tgds_sequencer_monitor (
	// clock and reset
	input wire logic        i_clock,
	input wire logic        i_rst,
	// register port
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	// host and transport lines
	input wire logic        i_command_strobe_n,
	input wire logic        o_motion,
	input wire logic        o_data_busy,
	input wire logic        o_command_busy
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// start and end of the timed steps
	sequence s_accept;
		$rose(o_command_busy);
	endsequence
	sequence s_post_end;
		$fell(o_data_busy);
	endsequence
	property p_busy_nest;
		o_data_busy |-> o_command_busy && o_motion;
	endproperty
	property p_accept_strobe;
		s_accept |-> $past(i_command_strobe_n, 2) == 1'b0;
	endproperty
	property p_accept_motion;
		s_accept |-> $rose(o_motion);
	endproperty
	property p_pre_min;
		s_accept |-> !o_data_busy [*8];
	endproperty
	property p_post_motion;
		s_post_end |-> $fell(o_motion);
	endproperty
	property p_halt_min;
		s_post_end |-> o_command_busy [*8];
	endproperty
	property p_command_busy_release;
		$fell(o_command_busy) |-> !o_data_busy && !o_motion && !$past(o_data_busy);
	endproperty
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	a_busy_nest: assert property (p_busy_nest)
		else $error("data busy outside command busy");
	a_accept_strobe: assert property (p_accept_strobe)
		else $error("command accepted without strobe");
	a_accept_motion: assert property (p_accept_motion)
		else $error("motion not raised at accept");
	a_pre_min: assert property (p_pre_min)
		else $error("predelay too short");
	a_post_motion: assert property (p_post_motion)
		else $error("motion not removed at postdelay end");
	a_halt_min: assert property (p_halt_min)
		else $error("halt delay too short");
	a_command_busy_release: assert property (p_command_busy_release)
		else $error("command busy dropped early");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read cycle");
endmodule // tgds_sequencer_monitor
bind tgds_sequencer tgds_sequencer_monitor u_tgds_sequencer_monitor (
	.i_clock(i_clock), .i_rst(i_rst), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_command_strobe_n(i_command_strobe_n), .o_motion(o_motion),
	.o_data_busy(o_data_busy), .o_command_busy(o_command_busy));
`default_nettype wire

// ### sim/tgds_host_model.sv
// Purpose: host adaptor and transport model issuing one command
// Assumes: bench raises i_go only while idle
// Notes: measures pre, post and halt intervals in clock cycles
`timescale 1ns/1ns
`default_nettype none
module tgds_host_model (
	// clock and request from bench
	input  wire logic i_clock,
	input  wire logic i_go,
	input  wire logic i_write,
	input  wire logic i_reverse,
	input  wire logic i_bot,
	input  wire logic i_retry,
	// busy lines from block
	input  wire logic i_data_busy,
	input  wire logic i_command_busy,
	// command pins and transport
	output logic      o_command_strobe_n,
	output logic      o_cmd_write,
	output logic      o_cmd_reverse,
	output logic      o_cmd_bot,
	output logic      o_load_point_marker,
	output logic      o_end_record_state,
	// measured intervals
	output var int    o_pre,
	output var int    o_post,
	output var int    o_halt,
	output logic      o_done
);
	time t0;
	// wait for a busy line to reach a level, bounded
	task automatic wait_for(input logic want, input logic sel);
		for (int n = 0; n < 20000 && (sel ? i_command_busy : i_data_busy) !== want; n++)
			@(posedge i_clock);
	endtask
	// one command with its record
	initial begin
		{o_cmd_write, o_cmd_reverse, o_cmd_bot, o_load_point_marker} = 4'h0;
		{o_end_record_state, o_done} = 2'h0;
		o_command_strobe_n = 1'b1;
		{o_pre, o_post, o_halt} = '0;
		forever begin
			@(posedge i_clock);
			if (i_go) begin
				o_cmd_write <= i_write;
				o_cmd_reverse <= i_reverse;
				o_cmd_bot <= i_bot;
				repeat (2) @(posedge i_clock);
				o_command_strobe_n <= 1'b0;
				t0 = $time;
				wait_for(1'b1, 1'b1);
				o_command_strobe_n <= 1'b1;
				// released lines stop showing the command
				o_cmd_write <= ~i_write;
				o_cmd_reverse <= ~i_reverse;
				o_cmd_bot <= ~i_bot;
				if (i_bot) begin
					repeat (10) @(posedge i_clock);
					o_load_point_marker <= 1'b1;
					t0 = $time;
				end
				wait_for(1'b1, 1'b0);
				o_pre = int'(($time - t0) / 40);
				repeat (20) @(posedge i_clock);
				if (i_retry) begin
					o_command_strobe_n <= 1'b0;
					repeat (4) @(posedge i_clock);
					o_command_strobe_n <= 1'b1;
				end
				o_end_record_state <= 1'b1;
				t0 = $time;
				wait_for(1'b0, 1'b0);
				o_post = int'(($time - t0) / 40);
				o_end_record_state <= 1'b0;
				o_load_point_marker <= 1'b0;
				t0 = $time;
				wait_for(1'b0, 1'b1);
				o_halt = int'(($time - t0) / 40);
				o_done <= 1'b1;
				@(posedge i_clock);
				o_done <= 1'b0;
			end
		end
	end
endmodule // tgds_host_model
`default_nettype wire

// ### sim/test_tgds_sequencer.sv
// Purpose: self-checking bench of the gap delay sequencer
// Assumes: scaled speed with short tick period keeps the run short
// Notes: intervals compared within a tick below and a tick plus six cycles above
`timescale 1ns/1ns
`default_nettype none
module test_tgds_sequencer;
	localparam int LIMIT = 60000;
	logic        i_clock, i_rst, i_wr, i_rd;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	logic        strobe_n, c_wr, c_rev, c_bot, lp, eor, motion, dbusy, command_busy;
	logic        go, op_w, op_r, op_b, op_t, done;
	int          pre_c, post_c, halt_c, period, cycles, miscompares, comparisons;
	// block and host model
	tgds_sequencer u_tgds_sequencer (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_command_strobe_n(strobe_n), .i_cmd_write(c_wr), .i_cmd_reverse(c_rev),
		.i_cmd_bot(c_bot), .i_load_point_marker(lp), .i_end_record_state(eor),
		.o_motion(motion), .o_data_busy(dbusy), .o_command_busy(command_busy));
	tgds_host_model u_tgds_host_model (.i_clock(i_clock), .i_go(go), .i_write(op_w),
		.i_reverse(op_r), .i_bot(op_b), .i_retry(op_t), .i_data_busy(dbusy),
		.i_command_busy(command_busy), .o_command_strobe_n(strobe_n), .o_cmd_write(c_wr),
		.o_cmd_reverse(c_rev), .o_cmd_bot(c_bot), .o_load_point_marker(lp),
		.o_end_record_state(eor), .o_pre(pre_c), .o_post(post_c), .o_halt(halt_c),
		.o_done(done));
	// clock
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	// register bus cycles
	task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// comparisons
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk_span(input string n, input int t, input int s);
		comparisons++;
		if (s < t * period - period || s > t * period + period + 6) begin
			miscompares++;
			$display("mismatch %s expected %0d seen %0d", n, t * period, s);
		end
	endtask
	// one command under a given configuration, tick counts expected;
	// nonzero ld: table-speed counter load read at accept, then scaled speed finishes
	task automatic run_op(input logic [3:0] cfg, input logic w, r, b, t, input int pre, post,
		input int ld = 0);
		reg_write(tgds_pkg::REG_CFG, {28'h0, cfg});
		op_w <= w;
		op_r <= r;
		op_b <= b;
		op_t <= t;
		go <= 1'b1;
		@(posedge i_clock);
		go <= 1'b0;
		if (ld != 0) begin
			for (int n = 0; n < 100 && command_busy !== 1'b1; n++)
				@(posedge i_clock);
			reg_read(tgds_pkg::REG_STATUS, d);
			chk_span("counter load", ld, int'(d[31:16]));
			reg_write(tgds_pkg::REG_CFG, {28'h0, cfg | 4'h3});
		end
		for (int n = 0; n < 30000 && done !== 1'b1; n++) begin
			@(posedge i_clock);
			#1;
		end
		chk_val("op done", 32'h1, {31'h0, done});
		chk_span("predelay", pre, pre_c);
		chk_span("postdelay", post, post_c);
		chk_span("halt delay", 566, halt_c);
		repeat (8) @(posedge i_clock);
		chk_val("command busy idle", 32'h0, {31'h0, command_busy});
		chk_val("motion idle", 32'h0, {31'h0, motion});
	endtask
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			summarize();
		end
	end
	// main sequence
	initial begin
		{i_rst, i_wr, i_rd, go, op_w, op_r, op_b, op_t} = 8'h80;
		{i_addr, i_wdata} = '0;
		{cycles, miscompares, comparisons, period} = {32'h0, 32'h0, 32'h0, 32'h1};
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		reg_read(tgds_pkg::REG_CFG, d);
		chk_val("cfg reset", {28'h0, tgds_pkg::CFG_RST}, d);
		reg_read(tgds_pkg::REG_SCALE, d);
		chk_val("scale reset", {16'h0, tgds_pkg::SCALE_RST}, d);
		reg_read(tgds_pkg::REG_STATUS, d);
		chk_val("status idle", 32'h0, d & 32'h0000003F);
		reg_read(4'hC, d);
		chk_val("unmapped", 32'h0, d);
		reg_write(tgds_pkg::REG_SCALE, 32'h0);
		reg_read(tgds_pkg::REG_SCALE, d);
		chk_val("scale zero", 32'h1, d);
		// scaled speed, 75 ips counts, one tick per clock
		run_op(4'h3, 0, 0, 0, 0, 366, 167);
		run_op(4'h3, 0, 1, 0, 0, 366, 0);
		run_op(4'hB, 0, 1, 0, 0, 366, 33);
		run_op(4'h3, 1, 0, 0, 0, 566, 266);
		run_op(4'h7, 0, 0, 0, 0, 366, 0);
		run_op(4'h7, 0, 1, 0, 0, 366, 167);
		run_op(4'hF, 0, 1, 0, 0, 366, 233);
		run_op(4'h7, 1, 0, 0, 1, 566, 33);
		run_op(4'h3, 0, 0, 1, 0, 1200, 167);
		run_op(4'h7, 1, 0, 1, 0, 5360, 33);
		// table speeds: counter load at accept, ten cycles of access before speed-up
		run_op(4'h1, 0, 0, 0, 0, tgds_pkg::T_PRE_RD_45 + 10, 167,
			tgds_pkg::T_PRE_RD_45);
		run_op(4'h2, 1, 0, 0, 0, tgds_pkg::T_PRE_WR_37 + 10, 266,
			tgds_pkg::T_PRE_WR_37);
		// slower speed clock stretches every interval
		reg_write(tgds_pkg::REG_SCALE, 32'h2);
		period = 2;
		run_op(4'h3, 0, 0, 0, 0, 366, 167);
		summarize();
	end
endmodule // test_tgds_sequencer
`default_nettype wire
